// [hw/mrf_memory_map.sv]
/*
 * Memory organisation between the core's shared instruction/data bus and
 * the on-chip SRAM and halfword-wide non-volatile program memory.
 * Assumes the core holds a request until bus_ready takes it, and that the
 * programming port is driven by logic on the same clock.
 */
`timescale 1ns/1ns
module mrf_memory_map (
    input wire logic clock,
    input wire logic rst,
    input wire logic bus_req,
    input wire logic [31:0] bus_addr,
    input wire logic bus_we,
    input wire logic [1:0] bus_size,
    input wire logic [31:0] bus_wdata,
    output logic bus_ready,
    output logic bus_ack,
    output logic bus_err,
    output logic [31:0] bus_rdata,
    input wire logic remap_wr,
    input wire logic [7:0] remap_wdata,
    output logic nv_at_zero,
    input wire logic prog_valid,
    input wire logic [14:0] prog_addr,
    input wire logic [15:0] prog_data,
    input wire logic erase_valid,
    input wire logic [6:0] erase_page,
    output logic prog_ready,
    output logic prog_err
);

    // ----------------------------------------------------------------
    // decoding
    // ----------------------------------------------------------------
    function automatic mrf_pkg::mrf_region_type decode(input logic [31:0] a, input logic at_zero);
        mrf_pkg::mrf_region_type rg;
        rg = mrf_pkg::MRF_RG_NONE;
        if (at_zero && a < mrf_pkg::MRF_NV_BYTES)
            rg = mrf_pkg::MRF_RG_NV;
        else if (!at_zero && a < mrf_pkg::MRF_SRAM_BYTES)
            rg = mrf_pkg::MRF_RG_SRAM;
        else if (a >= mrf_pkg::MRF_SRAM_BASE && a < mrf_pkg::MRF_SRAM_BASE + mrf_pkg::MRF_SRAM_BYTES)
            rg = mrf_pkg::MRF_RG_SRAM;
        else if (a >= mrf_pkg::MRF_NV_BASE && a < mrf_pkg::MRF_NV_BASE + mrf_pkg::MRF_NV_BYTES)
            rg = mrf_pkg::MRF_RG_NV;
        return rg;
    endfunction

    function automatic logic misaligned(input logic [1:0] sz, input logic [1:0] a);
        return (sz == mrf_pkg::MRF_SIZE_HALF && a[0]) || (sz == mrf_pkg::MRF_SIZE_WORD && a != 2'h0)
            || sz == 2'h3;
    endfunction

    function automatic logic [3:0] lanes(input logic [1:0] sz, input logic [1:0] a);
        logic [3:0] be;
        be = 4'hF;
        if (sz == mrf_pkg::MRF_SIZE_BYTE)
            be = 4'(4'h1 << a);
        else if (sz == mrf_pkg::MRF_SIZE_HALF)
            be = a[1] ? 4'hC : 4'h3;
        return be;
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] sram_mem [mrf_pkg::MRF_SRAM_WORDS];
    logic [15:0] nv_mem [mrf_pkg::MRF_NV_HALFWORDS];

    mrf_pkg::mrf_regs_type s, next_s;
    mrf_pkg::mrf_region_type rg;
    logic take, sram_we, nv_we;
    logic [3:0] sram_be;
    logic [10:0] sram_idx;
    logic [14:0] nv_widx;
    logic [15:0] nv_wdata, nv_rd;
    assign take = bus_req && s.ready;
    assign rg = decode(bus_addr, s.nv_at_zero);
    assign sram_idx = bus_addr[12:2];
    assign sram_be = lanes(bus_size, bus_addr[1:0]);
    assign nv_rd = nv_mem[s.hidx];

    // ----------------------------------------------------------------
    // next state
    // ----------------------------------------------------------------
    always_comb
    begin
        next_s = s;
        next_s.ack = 1'b0;
        next_s.err = 1'b0;
        next_s.prog_err = 1'b0;
        sram_we = 1'b0;
        nv_we = 1'b0;
        nv_widx = prog_addr;
        nv_wdata = prog_data;
        if (remap_wr)
            next_s.nv_at_zero = remap_wdata[mrf_pkg::MRF_REMAP_BIT];
        unique case (s.state)
            mrf_pkg::MRF_IDLE:
            begin
                if (s.erasing)
                begin
                    // one halfword per cycle keeps the array single-ported
                    nv_we = 1'b1;
                    nv_widx = {s.epage, s.ecount};
                    nv_wdata = mrf_pkg::MRF_NV_ERASED;
                    next_s.ecount = s.ecount + 8'h01;
                    if (s.ecount == 8'hFF)
                        next_s.erasing = 1'b0;
                end
                if (take)
                begin
                    if (misaligned(bus_size, bus_addr[1:0]) || rg == mrf_pkg::MRF_RG_NONE)
                    begin
                        next_s.ack = 1'b1;
                        next_s.err = 1'b1;
                    end
                    else if (rg == mrf_pkg::MRF_RG_SRAM)
                    begin
                        sram_we = bus_we;
                        next_s.rdata = sram_mem[sram_idx];
                        next_s.ack = 1'b1;
                    end
                    else if (bus_we)
                    begin
                        // program memory changes only through the programming port
                        next_s.ack = 1'b1;
                        next_s.err = 1'b1;
                    end
                    else
                    begin
                        next_s.hidx = bus_addr[15:1];
                        next_s.lane_hi = bus_addr[1];
                        next_s.size = bus_size;
                        next_s.wait_cnt = 3'h0;
                        next_s.state = mrf_pkg::MRF_NV_LO;
                    end
                end
                if (s.ready && prog_valid)
                begin
                    if (prog_addr >= mrf_pkg::MRF_NV_USER_HALFWORDS)
                        next_s.prog_err = 1'b1;
                    else
                        nv_we = 1'b1;
                end
                else if (s.ready && erase_valid)
                begin
                    if (erase_page >= mrf_pkg::MRF_NV_USER_PAGES)
                        next_s.prog_err = 1'b1;
                    else
                    begin
                        next_s.erasing = 1'b1;
                        next_s.epage = erase_page;
                        next_s.ecount = 8'h00;
                    end
                end
            end
            mrf_pkg::MRF_NV_LO:
            begin
                next_s.wait_cnt = s.wait_cnt + 3'h1;
                if (s.wait_cnt == mrf_pkg::MRF_NV_ACCESS_CYCLES - 3'h1)
                begin
                    if (s.size == mrf_pkg::MRF_SIZE_WORD)
                    begin
                        next_s.lo_half = nv_rd;
                        next_s.hidx = s.hidx + 15'h0001;
                        next_s.wait_cnt = 3'h0;
                        next_s.state = mrf_pkg::MRF_NV_HI;
                    end
                    else
                    begin
                        // halfword sits in its own lanes
                        next_s.rdata = s.lane_hi ? {nv_rd, 16'h0000} : {16'h0000, nv_rd};
                        next_s.ack = 1'b1;
                        next_s.state = mrf_pkg::MRF_IDLE;
                    end
                end
            end
            mrf_pkg::MRF_NV_HI:
            begin
                next_s.wait_cnt = s.wait_cnt + 3'h1;
                if (s.wait_cnt == mrf_pkg::MRF_NV_ACCESS_CYCLES - 3'h1)
                begin
                    next_s.rdata = {nv_rd, s.lo_half};
                    next_s.ack = 1'b1;
                    next_s.state = mrf_pkg::MRF_IDLE;
                end
            end
        endcase
        // the array is busy while erasing, so both ports stall
        next_s.ready = (next_s.state == mrf_pkg::MRF_IDLE) && !next_s.erasing;
    end

    always_ff @(posedge clock)
    begin
        if (rst)
            s <= mrf_pkg::MRF_RESET;
        else
            s <= next_s;
    end

    // ----------------------------------------------------------------
    // arrays
    // ----------------------------------------------------------------
    always_ff @(posedge clock)
    begin
        if (sram_we)
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (sram_be[i])
                    sram_mem[sram_idx][8 * i +: 8] <= bus_wdata[8 * i +: 8];
            end
        end
        if (nv_we)
            nv_mem[nv_widx] <= nv_wdata;
    end

    assign bus_ready = s.ready;
    assign bus_ack = s.ack;
    assign bus_err = s.err;
    assign bus_rdata = s.rdata;
    assign nv_at_zero = s.nv_at_zero;
    assign prog_ready = s.ready;
    assign prog_err = s.prog_err;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    property p_reset_mirror;
        @(posedge clock) rst |=> nv_at_zero && bus_ready;
    endproperty
    a_reset_mirror: assert property (p_reset_mirror) else $error("program memory not at zero after reset");
    property p_remap_clear;
        @(posedge clock) disable iff (rst) remap_wr && !remap_wdata[0] |=> !nv_at_zero;
    endproperty
    a_remap_clear: assert property (p_remap_clear) else $error("remap clear did not move SRAM to zero");
    property p_byte_lane;
        @(posedge clock) disable iff (rst)
            take && rg == mrf_pkg::MRF_RG_SRAM && bus_we && bus_size == mrf_pkg::MRF_SIZE_BYTE
            |=> sram_mem[$past(sram_idx)][8 * $past(bus_addr[1:0]) +: 8] == $past(bus_wdata[8 * bus_addr[1:0] +: 8]);
    endproperty
    a_byte_lane: assert property (p_byte_lane) else $error("byte not stored in its address lane");
    property p_misaligned;
        @(posedge clock) disable iff (rst) take && misaligned(bus_size, bus_addr[1:0]) |=> bus_ack && bus_err;
    endproperty
    a_misaligned: assert property (p_misaligned) else $error("misaligned transfer not refused");
    property p_boot_page;
        @(posedge clock) disable iff (rst)
            s.ready && !prog_valid && erase_valid && erase_page >= mrf_pkg::MRF_NV_USER_PAGES |=> prog_err && bus_ready;
    endproperty
    a_boot_page: assert property (p_boot_page) else $error("boot page erase not refused");
    property p_kernel_prog;
        @(posedge clock) disable iff (rst)
            s.ready && prog_valid && prog_addr >= mrf_pkg::MRF_NV_USER_HALFWORDS |=> prog_err;
    endproperty
    a_kernel_prog: assert property (p_kernel_prog) else $error("kernel area program not refused");
    property p_page_erase;
        @(posedge clock) disable iff (rst)
            s.ready && !prog_valid && erase_valid && erase_page < mrf_pkg::MRF_NV_USER_PAGES && !take
            |=> !bus_ready [*8] ##249 bus_ready;
    endproperty
    a_page_erase: assert property (p_page_erase) else $error("page erase not 256 cycles");
    property p_nv_word;
        @(posedge clock) disable iff (rst)
            take && rg == mrf_pkg::MRF_RG_NV && !bus_we && bus_size == mrf_pkg::MRF_SIZE_WORD && bus_addr[1:0] == 2'h0
            |=> !bus_ack [*8] ##1 !bus_ack [*4] ##1 bus_ack && !bus_err;
    endproperty
    a_nv_word: assert property (p_nv_word) else $error("word fetch not two paced halfword accesses");
    property p_nv_half;
        @(posedge clock) disable iff (rst)
            take && rg == mrf_pkg::MRF_RG_NV && !bus_we && bus_size == mrf_pkg::MRF_SIZE_HALF && !bus_addr[0]
            |=> !bus_ack [*6] ##1 bus_ack;
    endproperty
    a_nv_half: assert property (p_nv_half) else $error("halfword access not paced to 45 MHz");
    property p_sram_single;
        @(posedge clock) disable iff (rst)
            take && rg == mrf_pkg::MRF_RG_SRAM && !misaligned(bus_size, bus_addr[1:0]) |=> bus_ack && !bus_err;
    endproperty
    a_sram_single: assert property (p_sram_single) else $error("SRAM access not single cycle");
    property p_low_half;
        @(posedge clock) disable iff (rst)
            s.state == mrf_pkg::MRF_NV_HI && next_s.ack |=> bus_rdata[15:0] == $past(s.lo_half);
    endproperty
    a_low_half: assert property (p_low_half) else $error("lower halfword not in low bits");

endmodule

// [hw/mrf_pkg.sv]
/*
 * Shared constants and types for the memory map, remap and fetch block:
 * address map, array geometry, access sizes, pacing of the halfword-wide
 * program memory, and the state record of the block.
 * Assumes a single 250 MHz core clock and a synchronous active-high reset.
 */
package mrf_pkg;

    // ----------------------------------------------------------------
    // address map and array geometry
    // ----------------------------------------------------------------
    localparam logic [31:0] MRF_SRAM_BASE = 32'h0001_0000;
    localparam logic [31:0] MRF_NV_BASE = 32'h0008_0000;
    localparam logic [31:0] MRF_SRAM_BYTES = 32'h0000_2000;
    localparam logic [31:0] MRF_NV_BYTES = 32'h0001_0000;
    localparam int MRF_SRAM_WORDS = 2048;
    localparam int MRF_NV_HALFWORDS = 32768;
    localparam logic [14:0] MRF_NV_USER_HALFWORDS = 15'h7C00;
    localparam int MRF_PAGE_HALFWORDS = 256;
    localparam logic [6:0] MRF_NV_USER_PAGES = 7'h7C;
    localparam logic [15:0] MRF_NV_ERASED = 16'hFFFF;

    // ----------------------------------------------------------------
    // remap control and access sizes
    // ----------------------------------------------------------------
    localparam int MRF_REMAP_BIT = 0;
    localparam logic MRF_REMAP_RESET = 1'b1;
    localparam logic [1:0] MRF_SIZE_BYTE = 2'h0;
    localparam logic [1:0] MRF_SIZE_HALF = 2'h1;
    localparam logic [1:0] MRF_SIZE_WORD = 2'h2;

    // ----------------------------------------------------------------
    // pacing of program memory accesses
    // ----------------------------------------------------------------
    localparam int MRF_CLOCK_KHZ = 250000;
    localparam int MRF_NV_MAX_KHZ = 45000;
    localparam int MRF_NV_ACCESS_CYCLES_INT = (MRF_CLOCK_KHZ + MRF_NV_MAX_KHZ - 1) / MRF_NV_MAX_KHZ;
    localparam logic [2:0] MRF_NV_ACCESS_CYCLES = 3'(MRF_NV_ACCESS_CYCLES_INT);

    typedef enum logic [1:0] {MRF_IDLE, MRF_NV_LO, MRF_NV_HI} mrf_fsm_type;
    typedef enum logic [1:0] {MRF_RG_NONE, MRF_RG_SRAM, MRF_RG_NV} mrf_region_type;

    typedef struct packed {
        mrf_fsm_type state;
        logic nv_at_zero;
        logic ready;
        logic ack;
        logic err;
        logic [31:0] rdata;
        logic prog_err;
        logic erasing;
        logic [7:0] ecount;
        logic [6:0] epage;
        logic [2:0] wait_cnt;
        logic [14:0] hidx;
        logic lane_hi;
        logic [1:0] size;
        logic [15:0] lo_half;
    } mrf_regs_type;

    localparam mrf_regs_type MRF_RESET = '{
        state: MRF_IDLE, nv_at_zero: MRF_REMAP_RESET, ready: 1'b1, ack: 1'b0, err: 1'b0,
        rdata: 32'h0000_0000, prog_err: 1'b0, erasing: 1'b0, ecount: 8'h00, epage: 7'h00,
        wait_cnt: 3'h0, hidx: 15'h0000, lane_hi: 1'b0, size: 2'h0, lo_half: 16'h0000};

endpackage

// [sim/mrf_core_model.sv]
/*
 * Core-side bus master model for the memory map block.
 * Assumes the block takes a request at a rising edge with bus_ready high.
 */
`timescale 1ns/1ns
module mrf_core_model (
    input wire logic clock,
    input wire logic bus_ready,
    input wire logic bus_ack,
    input wire logic bus_err,
    input wire logic [31:0] bus_rdata,
    output logic bus_req,
    output logic [31:0] bus_addr,
    output logic bus_we,
    output logic [1:0] bus_size,
    output logic [31:0] bus_wdata
);
    initial
    begin
        bus_req = 1'b0;
        bus_addr = 32'h0000_0000;
        bus_we = 1'b0;
        bus_size = 2'h0;
        bus_wdata = 32'h0000_0000;
    end

    // released lines are inverted so a stale value can never pass as fresh
    task automatic access(input logic [31:0] a, input logic we, input logic [1:0] sz,
                          input logic [31:0] wd, output logic [31:0] rd, output logic er, output int lat);
        @(posedge clock);
        bus_req <= 1'b1;
        bus_addr <= a;
        bus_we <= we;
        bus_size <= sz;
        bus_wdata <= wd;
        @(posedge clock);
        for (int i = 0; i < 300 && bus_ready !== 1'b1; i++)
            @(posedge clock);
        bus_req <= 1'b0;
        bus_addr <= ~a;
        bus_we <= ~we;
        bus_size <= ~sz;
        bus_wdata <= ~wd;
        for (lat = 0; lat < 40; lat++)
        begin
            #1;
            if (bus_ack === 1'b1)
                break;
            @(posedge clock);
        end
        rd = bus_rdata;
        er = bus_err;
    endtask
endmodule

// [sim/tb.sv]
/*
 * Self-checking bench for the memory map, remap and fetch block.
 * Assumes mrf_core_model drives the core bus; clock 250 MHz.
 */
`timescale 1ns/1ns
module tb;
    logic clock, rst, bus_req, bus_we, bus_ready, bus_ack, bus_err, er;
    logic remap_wr, nv_at_zero, prog_valid, erase_valid, prog_ready, prog_err;
    logic [31:0] bus_addr, bus_wdata, bus_rdata, rd;
    logic [1:0] bus_size;
    logic [7:0] remap_wdata;
    logic [14:0] prog_addr;
    logic [15:0] prog_data;
    logic [6:0] erase_page;
    int lat, lat_sram;
    int n_fail = 0;
    int samples_checked = 0;
    localparam logic [31:0] sram = mrf_pkg::MRF_SRAM_BASE;
    localparam logic [31:0] sram_top = mrf_pkg::MRF_SRAM_BASE + mrf_pkg::MRF_SRAM_BYTES - 32'h4;
    localparam logic [31:0] nvm = mrf_pkg::MRF_NV_BASE;
    localparam logic [1:0] sz_b = mrf_pkg::MRF_SIZE_BYTE;
    localparam logic [1:0] sz_h = mrf_pkg::MRF_SIZE_HALF;
    localparam logic [1:0] sz_w = mrf_pkg::MRF_SIZE_WORD;

    mrf_memory_map u_mrf_memory_map (
        .clock, .rst, .bus_req, .bus_addr, .bus_we, .bus_size, .bus_wdata, .bus_ready, .bus_ack,
        .bus_err, .bus_rdata, .remap_wr, .remap_wdata, .nv_at_zero, .prog_valid, .prog_addr,
        .prog_data, .erase_valid, .erase_page, .prog_ready, .prog_err
    );
    mrf_core_model u_mrf_core_model (
        .clock, .bus_ready, .bus_ack, .bus_err, .bus_rdata, .bus_req, .bus_addr, .bus_we,
        .bus_size, .bus_wdata
    );

    initial
    begin
        clock = 1'b0;
        forever #2 clock = ~clock;
    end

    // --------------------------------
    // compares and bus helpers
    // --------------------------------
    task automatic check_val(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("ERROR t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic check_bit(input logic got, input logic exp);
        check_val({31'h0, got}, {31'h0, exp});
    endtask

    // d is write data for writes, expected word for reads
    task automatic acc(input logic [31:0] a, input logic we, input logic [1:0] sz, input logic [31:0] d,
                       input logic exp_err);
        u_mrf_core_model.access(a, we, sz, d, rd, er, lat);
        check_bit(lat < 40, 1'b1);
        check_bit(er, exp_err);
        if (!we && !exp_err)
            check_val(rd, d);
    endtask

    // err pulse may land one edge either side, so both samples count
    task automatic prog_op(input logic erase, input logic [14:0] a, input logic [15:0] d,
                           input logic exp_err, input int exp_lows);
        logic seen;
        int lows;
        seen = 1'b0;
        lows = 0;
        @(posedge clock);
        prog_valid <= !erase;
        erase_valid <= erase;
        prog_addr <= a;
        erase_page <= a[6:0];
        prog_data <= d;
        @(posedge clock);
        prog_valid <= 1'b0;
        erase_valid <= 1'b0;
        prog_addr <= ~a;
        erase_page <= ~a[6:0];
        prog_data <= ~d;
        for (int i = 0; i < 300; i++)
        begin
            #1;
            if (i < 2 && prog_err === 1'b1)
                seen = 1'b1;
            if (prog_ready !== 1'b1)
                lows++;
            @(posedge clock);
        end
        check_bit(seen, exp_err);
        check_val(32'(lows), 32'(exp_lows));
    endtask

    task automatic set_remap(input logic [7:0] v);
        @(posedge clock);
        remap_wr <= 1'b1;
        remap_wdata <= v;
        @(posedge clock);
        remap_wr <= 1'b0;
        remap_wdata <= ~v;
        @(posedge clock);
        #1;
        check_bit(nv_at_zero, v[0]);
    endtask

    task automatic test_reset_state();
        @(posedge clock);
        #1;
        check_bit(nv_at_zero, 1'b1);
        check_bit(bus_ready, 1'b1);
    endtask

    task automatic test_nv_fetch();
        prog_op(1'b0, 15'h0000, 16'h1234, 1'b0, 0);
        prog_op(1'b0, 15'h0001, 16'hABCD, 1'b0, 0);
        acc(sram, 1'b1, sz_w, 32'h4433_2211, 1'b0);
        acc(sram, 1'b0, sz_w, 32'h4433_2211, 1'b0);
        lat_sram = lat;
        check_bit(lat_sram <= 1, 1'b1);
        acc(nvm, 1'b0, sz_w, 32'hABCD_1234, 1'b0);
        check_val(32'(lat - lat_sram), 32'h0000_000C);
        acc(nvm + 32'h2, 1'b0, sz_h, 32'hABCD_0000, 1'b0);
        check_val(32'(lat - lat_sram), 32'h0000_0006);
        acc(32'h0000_0000, 1'b0, sz_w, 32'hABCD_1234, 1'b0);
        acc(32'h0000_0001, 1'b0, sz_b, 32'h0000_1234, 1'b0);
    endtask

    task automatic test_sram_lanes();
        acc(sram + 32'h3, 1'b1, sz_b, 32'hAA00_0000, 1'b0);
        acc(sram, 1'b1, sz_h, 32'h0000_BEEF, 1'b0);
        acc(sram + 32'h1, 1'b0, sz_b, 32'hAA33_BEEF, 1'b0);
        acc(sram_top, 1'b1, sz_w, 32'h5A5A_0F0F, 1'b0);
        acc(sram_top, 1'b0, sz_w, 32'h5A5A_0F0F, 1'b0);
        acc(sram + mrf_pkg::MRF_SRAM_BYTES, 1'b0, sz_w, 32'h0, 1'b1);
    endtask

    task automatic test_remap_refuse();
        set_remap(8'hFE);
        acc(32'h0000_0000, 1'b0, sz_w, 32'hAA33_BEEF, 1'b0);
        acc(32'h0000_2000, 1'b0, sz_w, 32'h0, 1'b1);
        set_remap(8'h01);
        acc(nvm, 1'b1, sz_w, 32'h0, 1'b1);
        acc(sram, 1'b0, 2'h3, 32'h0, 1'b1);
        acc(sram + 32'h1, 1'b0, sz_h, 32'h0, 1'b1);
        acc(sram + 32'h2, 1'b0, sz_w, 32'h0, 1'b1);
        acc(32'h0004_0000, 1'b0, sz_w, 32'h0, 1'b1);
    endtask

    task automatic test_protect_erase();
        prog_op(1'b0, mrf_pkg::MRF_NV_USER_HALFWORDS, 16'h1111, 1'b1, 0);
        prog_op(1'b0, 15'h7BFF, 16'h5555, 1'b0, 0);
        prog_op(1'b0, 15'h0100, 16'h7777, 1'b0, 0);
        prog_op(1'b1, {8'h00, mrf_pkg::MRF_NV_USER_PAGES}, 16'h0000, 1'b1, 0);
        prog_op(1'b1, 15'h0000, 16'h0000, 1'b0, 256);
        acc(nvm, 1'b0, sz_w, 32'hFFFF_FFFF, 1'b0);
        acc(nvm + 32'h200, 1'b0, sz_h, 32'h0000_7777, 1'b0);
        acc(nvm + 32'hF7FE, 1'b0, sz_h, 32'h5555_0000, 1'b0);
    endtask

    task automatic test_mid_reset();
        set_remap(8'h00);
        @(posedge clock);
        rst <= 1'b1;
        repeat (2) @(posedge clock);
        rst <= 1'b0;
        test_reset_state();
        acc(32'h0000_0000, 1'b0, sz_w, 32'hFFFF_FFFF, 1'b0);
    endtask

    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial
    begin
        repeat (20000) @(posedge clock);
        n_fail++;
        complete_run();
    end

    initial
    begin
        rst = 1'b1;
        remap_wr = 1'b0;
        remap_wdata = 8'h00;
        prog_valid = 1'b0;
        prog_addr = 15'h0000;
        prog_data = 16'h0000;
        erase_valid = 1'b0;
        erase_page = 7'h00;
        repeat (20) @(posedge clock);
        rst <= 1'b0;
        test_reset_state();
        test_nv_fetch();
        test_sram_lanes();
        test_remap_refuse();
        test_protect_erase();
        test_mid_reset();
        complete_run();
    end
endmodule
